// ===== dv/twc_ctrl_asserts.sv
// Checker of twc_timer_ctrl: bus, pin and command relations.
// Assumes a bind onto the block; it sees only the block's ports.
module twc_ctrl_asserts
  import twc_pkg::*;
#(
  parameter int CHANNELS = 3
) (
  // Clock and bus
  input wire logic clock,
  input wire logic reset,
  input twc_pkg::twc_apb_req_t apb_req,
  input twc_pkg::twc_apb_rsp_t apb_rsp,
  // Pins and status
  input wire logic [CHANNELS-1:0] port_value,
  input wire logic [CHANNELS-1:0] waveform_pin_output,
  input wire logic [CHANNELS-1:0] pin_override_active,
  input wire logic timer_running,
  input wire logic dual_eight_bit_select,
  input wire logic count_direction
);
  wire logic [CHANNELS-1:0] loose = (waveform_pin_output ^ port_value) & ~pin_override_active;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence acc_s(logic w, logic [7:0] i);
    apb_req.psel && apb_req.penable && apb_req.pwrite == w && apb_req.paddr == {2'h0, i, 2'h0};
  endsequence
  sequence cmd_s(logic [1:0] c);
    acc_s(1'b1, IDX_COMMAND_DIRECTION_SET) ##0 apb_req.pwdata[3:2] == c;
  endsequence
  pin_follow_a: assert property (loose == '0)
    else $error("pin left port value");
  run_bit_a: assert property (acc_s(1'b1, IDX_CONTROL_A) |=>
    timer_running == $past(apb_req.pwdata[0])) else $error("enable lost");
  split_bit_a: assert property (acc_s(1'b1, IDX_SPLIT_SELECT_CONTROL) |=>
    dual_eight_bit_select == $past(apb_req.pwdata[0])) else $error("split lost");
  dir_set_a: assert property (cmd_s(2'h0) ##0 apb_req.pwdata[0] |=> count_direction)
    else $error("direction not set");
  cmd_read_a: assert property (
    (acc_s(1'b0, IDX_COMMAND_DIRECTION_SET) or acc_s(1'b0, IDX_COMMAND_DIRECTION_CLEAR))
    |-> apb_rsp.prdata[3:2] == 2'h0 && apb_rsp.prdata[0] == $past(count_direction))
    else $error("bad readback");
  hold_run_a: assert property (cmd_s(2'h3) ##0 timer_running |=> timer_running)
    else $error("reset while running");
  hard_rst_a: assert property (
    cmd_s(2'h3) ##0 !timer_running ##0 apb_req.pwdata[1:0] == 2'h0
    |=> !count_direction && !dual_eight_bit_select && pin_override_active == '0)
    else $error("hard reset incomplete");
  no_wave_a: assert property (
    acc_s(1'b1, IDX_WAVEFORM_MODE_CONTROL) ##0
    (apb_req.pwdata[2:0] inside {3'h0, 3'h2, 3'h4} || apb_req.pwdata[6:4] == 3'h0)
    |=> ##1 pin_override_active == '0) else $error("override without waveform");
endmodule
bind twc_timer_ctrl twc_ctrl_asserts #(.CHANNELS(CHANNELS)) chk_u (.clock(clock),
  .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp), .port_value(port_value),
  .waveform_pin_output(waveform_pin_output), .pin_override_active(pin_override_active),
  .timer_running(timer_running), .dual_eight_bit_select(dual_eight_bit_select),
  .count_direction(count_direction));

// ===== dv/twc_timer_ctrl_tb.sv
// Bench of twc_timer_ctrl driven over APB.
// Assumes the checker is bound from its own file.
module twc_timer_ctrl_tb import twc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] SET = 10'(IDX_COMMAND_DIRECTION_SET);
  localparam logic [9:0] CLR = 10'(IDX_COMMAND_DIRECTION_CLEAR);
  localparam logic [9:0] MODE = 10'(IDX_WAVEFORM_MODE_CONTROL);
  localparam logic [9:0] CBUF = 10'(IDX_COMPARE_BUFFER_BASE);
  logic clock = 0;
  logic reset = 1;
  twc_apb_req_t req = '0;
  twc_apb_rsp_t rsp;
  logic [2:0] port_value = 3'h2;
  logic [2:0] pins, ovr;
  logic run, split, dir, err;
  logic [31:0] q;
  int errors = 0;
  int comparisons = 0;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
  twc_timer_ctrl dut_u (.clock(clock), .reset(reset), .apb_req(req), .apb_rsp(rsp),
    .port_value(port_value), .waveform_pin_output(pins), .pin_override_active(ovr),
    .timer_running(run), .dual_eight_bit_select(split), .count_direction(dir));
  initial forever #12.5 clock = ~clock;
  task automatic wrap_up;
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200us;
    errors++;
    wrap_up;
  end
  // -------------------------------------------------------------------
  // Bus tasks
  // -------------------------------------------------------------------
  // The request stands until pready is seen high, so no wait count is assumed.
  task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d);
    @(posedge clock);
    req <= '{1'b1, 1'b0, w, {i, 2'h0}, d, 4'hf};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    xfer(1'b1, i, d);
  endtask
  task automatic rd(input logic [9:0] i, input logic [15:0] e);
    xfer(1'b0, i, 32'h0);
    `CHK("register", e, q[15:0])
  endtask
  task automatic look;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_regs;
    for (int k = 2; k < 8; k++) rd(10'(k), 16'h0);
    wr(SET, 32'h3);
    rd(CLR, 16'h3);
    wr(CLR, 32'h1);
    rd(SET, 16'h2);
    wr(SET, 32'h0);
    rd(CLR, 16'h2);
    wr(10'(IDX_SPLIT_SELECT_CONTROL), 32'h1);
    look;
    `CHK("split", 1'b1, split)
    wr(10'(IDX_SPLIT_SELECT_CONTROL), 32'h0);
    xfer(1'b0, 10'h300, 32'h0);
    `CHK("slverr", 1'b1, err)
  endtask
  task automatic t_buf;
    wr(10'(IDX_PERIOD_BUFFER), 32'h1234);
    for (int k = 0; k < 3; k++) wr(CBUF + 10'(2 * k), 32'h100 + k);
    rd(10'(IDX_BUFFER_VALID_SET), 16'hf);
    wr(SET, 32'h4);
    rd(10'(IDX_BUFFER_VALID_CLEAR), 16'hf);
    rd(10'(IDX_PERIOD), 16'hffff);
    wr(CLR, 32'h2);
    wr(SET, 32'h4);
    rd(10'(IDX_BUFFER_VALID_SET), 16'h0);
    rd(10'(IDX_PERIOD), 16'h1234);
    rd(10'(IDX_COMPARE_BASE) + 10'h4, 16'h102);
    rd(SET, 16'h0);
    wr(10'(IDX_BUFFER_VALID_SET), 32'h9);
    wr(10'(IDX_BUFFER_VALID_CLEAR), 32'h1);
    rd(10'(IDX_BUFFER_VALID_CLEAR), 16'h8);
  endtask
  task automatic t_auto;
    wr(MODE, 32'h39);
    rd(SET, 16'h2);
    wr(CBUF, 32'h40);
    rd(SET, 16'h2);
    wr(CBUF + 10'h2, 32'h41);
    rd(SET, 16'h0);
    rd(10'(IDX_COMPARE_BASE), 16'h100);
    wr(SET, 32'h4);
    rd(SET, 16'h2);
    rd(10'(IDX_COMPARE_BASE), 16'h40);
    wr(MODE, 32'h30);
    wr(CBUF, 32'h42);
    wr(CBUF + 10'h2, 32'h43);
    rd(SET, 16'h2);
  endtask
  task automatic t_pins;
    for (int m = 0; m < 8; m++) begin
      wr(MODE, 32'h70 | m);
      look;
      `CHK("override", (m inside {1, 3, 5, 6, 7}) ? 3'h7 : 3'h0, ovr)
    end
    wr(MODE, 32'h11);
    wr(10'(IDX_OUTPUT_VALUE_CONTROL), 32'h5);
    look;
    `CHK("pins", 3'h3, pins)
    wr(10'(IDX_CONTROL_A), 32'h1);
    wr(SET, 32'hc);
    look;
    `CHK("run", 1'b1, run)
    wr(10'(IDX_CONTROL_A), 32'h0);
    wr(SET, 32'hc);
    rd(MODE, 16'h0);
  endtask
  task automatic t_count;
    wr(10'(IDX_PERIOD), 32'h3);
    wr(10'(IDX_PERIOD_BUFFER), 32'h5);
    wr(10'(IDX_CONTROL_A), 32'h3);
    repeat (16) @(posedge clock);
    wr(10'(IDX_CONTROL_A), 32'h0);
    rd(10'(IDX_PERIOD), 16'h5);
    rd(10'(IDX_BUFFER_VALID_SET), 16'h0);
    rd(10'(IDX_FLAGS), 16'h1);
    wr(10'(IDX_FLAGS), 32'h1);
    rd(10'(IDX_FLAGS), 16'h0);
    wr(10'(IDX_COUNT), 32'h7);
    wr(SET, 32'h1);
    look;
    `CHK("dir", 1'b1, dir)
    wr(SET, 32'h8);
    look;
    `CHK("dir", 1'b0, dir)
    rd(10'(IDX_COUNT), 16'h0);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    t_regs;
    t_buf;
    t_auto;
    t_pins;
    t_count;
    wrap_up;
  end
endmodule

// ===== logic/twc_timer_ctrl.sv
// Control logic of a 16-bit timer/counter: waveform modes, pin override,
// buffered period and compare registers with lock handling, commands.
// Assumes an APB master on the same clock and port values from same-clock logic.

// Notes on behaviour
// - Waveform modes: set override bit makes waveform replace port value on that pin.
// - Writing auto lock one sets lock until all enabled compare buffers are valid.
// - Under auto lock, lock stays clear until update, which transfers and relocks.
// - With auto lock off, only software writes change the lock bit.
// - Mode 000: normal, period is top, update and wrap at top, no waveform.
// - Mode 001: frequency, compare zero is top, update and wrap at top.
// - Mode 011: single-ramp PWM, period top, update and wrap at bottom.
// - Modes 101/110/111: two-ramp PWM, update at bottom, wrap at top/both/bottom.
// - Waveform reaches pins only on override-enabled channels; software sets pin direction.
// - While stopped, writing an output value bit sets that channel's waveform value.
// - The split bit stops the 16-bit counter; the two 8-bit halves live elsewhere.
// - Clear-type register: writing one clears the bit, zero leaves it.
// - Set-type register: writing one sets the bit, zero leaves it.
// - Set and clear addresses of a pair read the same status bits.
// - The command field acts on write only and reads as zero.
// - Command 1 updates, 2 restarts, 3 hard resets unless enabled, 0 nothing.
// - While locked, no buffered values transfer at an update.
// - While unlocked, buffered values transfer at every update.
// - Direction bit: zero counts up, one down; hardware or software may change it.
// - Compare buffer valid sets on buffer write and clears at an unlocked update.
// - Period buffer valid sets on period buffer write and clears at an unlocked update.
// - Timer ticks at clock divided by 1,2,4,8,16,64,256 or 1024.
// - One enable bit starts the timer; it gates hard reset and output writes.
// - Wrap flag sets at mode's top or bottom and stays until written one.
module twc_timer_ctrl
  import twc_pkg::*;
#(
  parameter int CHANNELS = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register bus
  input twc_pkg::twc_apb_req_t apb_req,
  output twc_pkg::twc_apb_rsp_t apb_rsp,
  // Pins
  input wire logic [CHANNELS-1:0] port_value,
  output logic [CHANNELS-1:0] waveform_pin_output,
  output logic [CHANNELS-1:0] pin_override_active,
  // Status
  output logic timer_running,
  output logic dual_eight_bit_select,
  output logic count_direction
);
  import twc_pkg::*;

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic [2:0] prescale_select;
    logic [CHANNELS-1:0] compare_pin_override_enable;
    logic auto_lock_transfer;
    logic [2:0] waveform_select;
    logic dual_eight_bit_select;
    logic transfer_lock;
    logic direction;
    logic [CHANNELS-1:0] compare_buffer_valid;
    logic period_buffer_valid;
    logic wrap_flag;
    logic [CHANNELS-1:0] wave;
    logic [9:0] prescale_count;
    logic [15:0] count;
    logic [15:0] period_value;
    logic [15:0] period_buffer;
    logic [CHANNELS-1:0][15:0] compare_value;
    logic [CHANNELS-1:0][15:0] compare_buffer;
    logic [31:0] rdata;
    logic err;
  } twc_state_t;

  twc_state_t state_q;
  twc_state_t state_d;

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  // Divisor exponents 0,1,2,3,4,6,8,10; the tick fires when the low bits
  // of the free-running prescale count are all ones.
  function automatic logic prescale_tick(input logic [9:0] pc, input logic [2:0] sel);
    logic [9:0] mask;
    mask = 10'h000;
    unique case (sel)
      3'h0: mask = 10'h000;
      3'h1: mask = 10'h001;
      3'h2: mask = 10'h003;
      3'h3: mask = 10'h007;
      3'h4: mask = 10'h00f;
      3'h5: mask = 10'h03f;
      3'h6: mask = 10'h0ff;
      3'h7: mask = 10'h3ff;
    endcase
    return (pc & mask) == mask;
  endfunction

  // Byte-lane merge for the 16-bit registers.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  function automatic logic two_ramp(input logic [2:0] m);
    return m == WAVE_TWO_RAMP_FLAG_AT_PEAK || m == WAVE_TWO_RAMP_FLAG_AT_BOTH ||
           m == WAVE_TWO_RAMP_FLAG_AT_FLOOR;
  endfunction

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  logic [7:0] idx;
  logic wr;
  logic setup;
  logic [7:0] wb;
  logic [1:0] cmd;
  logic tick;
  logic [15:0] top;
  logic top_ev;
  logic bot_ev;
  logic update_ev;
  logic xfer;
  logic [CHANNELS-1:0] match;
  logic [CHANNELS-1:0] buf_wr;
  logic mapped;
  logic [31:0] rd;

  always_comb begin
    state_d = state_q;
    idx = apb_req.paddr[9:2];
    setup = apb_req.psel && !apb_req.penable;
    wr = apb_req.psel && apb_req.penable && apb_req.pwrite && (apb_req.paddr[11:10] == 2'h0);
    wb = apb_req.pstrb[0] ? apb_req.pwdata[7:0] : 8'h00;
    cmd = CMD_NONE;
    buf_wr = '0;
    top_ev = 1'b0;
    bot_ev = 1'b0;
    match = '0;

    // Counting stops in split mode; the two 8-bit halves live elsewhere.
    tick = state_q.enable && !state_q.dual_eight_bit_select &&
           prescale_tick(state_q.prescale_count, state_q.prescale_select);
    top = (state_q.waveform_select == WAVE_FREQUENCY) ? state_q.compare_value[0]
                                                       : state_q.period_value;
    state_d.prescale_count = state_q.enable ? state_q.prescale_count + 10'h001 : 10'h000;

    // Counter sequence.
    if (tick) begin
      for (int n = 0; n < CHANNELS; n++) begin
        match[n] = state_q.count == state_q.compare_value[n];
      end
      if (two_ramp(state_q.waveform_select)) begin
        if (!state_q.direction) begin
          if (state_q.count >= top) begin
            top_ev = 1'b1;
            state_d.direction = 1'b1;
            state_d.count = top - 16'h0001;
          end else begin
            state_d.count = state_q.count + 16'h0001;
          end
        end else begin
          if (state_q.count == 16'h0000) begin
            bot_ev = 1'b1;
            state_d.direction = 1'b0;
            state_d.count = 16'h0001;
          end else begin
            state_d.count = state_q.count - 16'h0001;
          end
        end
      end else begin
        // One-ramp modes: the wrap is both TOP and BOTTOM.
        if (!state_q.direction) begin
          if (state_q.count >= top) begin
            top_ev = 1'b1;
            bot_ev = 1'b1;
            state_d.count = 16'h0000;
          end else begin
            state_d.count = state_q.count + 16'h0001;
          end
        end else begin
          if (state_q.count == 16'h0000) begin
            top_ev = 1'b1;
            bot_ev = 1'b1;
            state_d.count = top;
          end else begin
            state_d.count = state_q.count - 16'h0001;
          end
        end
      end
    end

    // Waveform generation; normal and reserved modes leave it untouched.
    unique case (state_q.waveform_select)
      WAVE_FREQUENCY: begin
        for (int n = 0; n < CHANNELS; n++) begin
          if (match[n]) begin
            state_d.wave[n] = ~state_q.wave[n];
          end
        end
      end
      WAVE_ONE_RAMP_PWM: begin
        for (int n = 0; n < CHANNELS; n++) begin
          if (bot_ev) begin
            state_d.wave[n] = 1'b1;
          end
          if (match[n]) begin
            state_d.wave[n] = 1'b0;
          end
        end
      end
      WAVE_TWO_RAMP_FLAG_AT_PEAK, WAVE_TWO_RAMP_FLAG_AT_BOTH, WAVE_TWO_RAMP_FLAG_AT_FLOOR: begin
        for (int n = 0; n < CHANNELS; n++) begin
          if (match[n]) begin
            state_d.wave[n] = state_q.direction;
          end
        end
      end
      default: begin
      end
    endcase

    // Software writes.
    if (wr) begin
      unique case (idx)
        IDX_CONTROL_A: begin
          if (apb_req.pstrb[0]) begin
            state_d.enable = wb[ENABLE_BIT];
            state_d.prescale_select = wb[PRESCALE_LSB +: 3];
          end
        end
        IDX_WAVEFORM_MODE_CONTROL: begin
          if (apb_req.pstrb[0]) begin
            state_d.waveform_select = wb[WAVEFORM_SELECT_LSB +: 3];
            state_d.auto_lock_transfer = wb[AUTO_LOCK_BIT];
            state_d.compare_pin_override_enable = wb[OVERRIDE_LSB +: CHANNELS];
            if (wb[AUTO_LOCK_BIT]) begin
              state_d.transfer_lock = 1'b1;
            end
          end
        end
        IDX_OUTPUT_VALUE_CONTROL: begin
          if (apb_req.pstrb[0] && !state_q.enable) begin
            state_d.wave = wb[CHANNELS-1:0];
          end
        end
        IDX_SPLIT_SELECT_CONTROL: begin
          if (apb_req.pstrb[0]) begin
            state_d.dual_eight_bit_select = wb[SPLIT_BIT];
          end
        end
        IDX_COMMAND_DIRECTION_CLEAR: begin
          cmd = wb[COMMAND_LSB +: 2];
          if (wb[DIRECTION_BIT]) begin
            state_d.direction = 1'b0;
          end
          if (wb[LOCK_BIT]) begin
            state_d.transfer_lock = 1'b0;
          end
        end
        IDX_COMMAND_DIRECTION_SET: begin
          cmd = wb[COMMAND_LSB +: 2];
          if (wb[DIRECTION_BIT]) begin
            state_d.direction = 1'b1;
          end
          if (wb[LOCK_BIT]) begin
            state_d.transfer_lock = 1'b1;
          end
        end
        IDX_FLAGS: begin
          if (wb[WRAP_FLAG_BIT]) begin
            state_d.wrap_flag = 1'b0;
          end
        end
        IDX_COUNT: begin
          state_d.count = merge16(state_q.count, apb_req.pwdata, apb_req.pstrb);
        end
        IDX_PERIOD: begin
          state_d.period_value = merge16(state_q.period_value, apb_req.pwdata, apb_req.pstrb);
        end
        IDX_PERIOD_BUFFER: begin
          state_d.period_buffer = merge16(state_q.period_buffer, apb_req.pwdata,
                                          apb_req.pstrb);
        end
        default: begin
        end
      endcase
      for (int n = 0; n < CHANNELS; n++) begin
        if (idx == IDX_COMPARE_BASE + 8'(2 * n)) begin
          state_d.compare_value[n] = merge16(state_q.compare_value[n], apb_req.pwdata,
                                             apb_req.pstrb);
        end
        if (idx == IDX_COMPARE_BUFFER_BASE + 8'(2 * n)) begin
          state_d.compare_buffer[n] = merge16(state_q.compare_buffer[n], apb_req.pwdata,
                                              apb_req.pstrb);
          buf_wr[n] = 1'b1;
        end
      end
    end

    // Update condition per mode, plus the forced update.
    unique case (state_q.waveform_select)
      WAVE_NORMAL, WAVE_FREQUENCY: update_ev = top_ev;
      WAVE_ONE_RAMP_PWM, WAVE_TWO_RAMP_FLAG_AT_PEAK, WAVE_TWO_RAMP_FLAG_AT_BOTH,
      WAVE_TWO_RAMP_FLAG_AT_FLOOR: update_ev = bot_ev;
      default: update_ev = 1'b0;
    endcase
    if (cmd == CMD_UPDATE) begin
      update_ev = 1'b1;
    end
    xfer = update_ev && !state_q.transfer_lock;

    // Wrap flag; a set in the clearing cycle wins.
    unique case (state_q.waveform_select)
      WAVE_NORMAL, WAVE_FREQUENCY, WAVE_TWO_RAMP_FLAG_AT_PEAK: begin
        if (top_ev) begin
          state_d.wrap_flag = 1'b1;
        end
      end
      WAVE_ONE_RAMP_PWM, WAVE_TWO_RAMP_FLAG_AT_FLOOR: begin
        if (bot_ev) begin
          state_d.wrap_flag = 1'b1;
        end
      end
      WAVE_TWO_RAMP_FLAG_AT_BOTH: begin
        if (top_ev || bot_ev) begin
          state_d.wrap_flag = 1'b1;
        end
      end
      default: begin
      end
    endcase

    // Buffer transfer and valid bits; a buffer write in the transfer cycle
    // keeps its valid bit so the new value is not forgotten.
    if (xfer) begin
      state_d.period_value = state_q.period_buffer;
      state_d.compare_value = state_q.compare_buffer;
      state_d.compare_buffer_valid = '0;
      state_d.period_buffer_valid = 1'b0;
      if (state_q.auto_lock_transfer) begin
        state_d.transfer_lock = 1'b1;
      end
    end
    if (wr && idx == IDX_BUFFER_VALID_CLEAR) begin
      state_d.compare_buffer_valid = state_d.compare_buffer_valid &
                                     ~wb[1 +: CHANNELS];
      if (wb[0]) begin
        state_d.period_buffer_valid = 1'b0;
      end
    end
    if (wr && idx == IDX_BUFFER_VALID_SET) begin
      state_d.compare_buffer_valid = state_d.compare_buffer_valid | wb[1 +: CHANNELS];
      state_d.period_buffer_valid = state_d.period_buffer_valid | wb[0];
    end
    state_d.compare_buffer_valid = state_d.compare_buffer_valid | buf_wr;
    if (wr && idx == IDX_PERIOD_BUFFER) begin
      state_d.period_buffer_valid = 1'b1;
    end

    // Auto lock release once every enabled channel holds a fresh buffer.
    if (state_q.auto_lock_transfer && state_q.transfer_lock &&
        ((state_q.compare_buffer_valid & state_q.compare_pin_override_enable) ==
         state_q.compare_pin_override_enable)) begin
      state_d.transfer_lock = 1'b0;
    end

    // Restart and hard reset commands.
    if (cmd == CMD_RESTART) begin
      state_d.count = 16'h0000;
      state_d.direction = 1'b0;
      state_d.prescale_count = 10'h000;
      state_d.wave = '0;
    end
    if (cmd == CMD_HARD_RESET && !state_q.enable) begin
      state_d = '0;
      state_d.period_value = PERIOD_RESET;
      state_d.period_buffer = PERIOD_RESET;
    end

    // Read data is captured in the setup cycle and held through access.
    rd = 32'h0000_0000;
    mapped = apb_req.paddr[11:10] == 2'h0;
    unique case (idx)
      IDX_CONTROL_A: rd[7:0] = {4'h0, state_q.prescale_select, state_q.enable};
      IDX_WAVEFORM_MODE_CONTROL: begin
        rd[OVERRIDE_LSB +: CHANNELS] = state_q.compare_pin_override_enable;
        rd[AUTO_LOCK_BIT] = state_q.auto_lock_transfer;
        rd[WAVEFORM_SELECT_LSB +: 3] = state_q.waveform_select;
      end
      IDX_OUTPUT_VALUE_CONTROL: rd[CHANNELS-1:0] = state_q.wave;
      IDX_SPLIT_SELECT_CONTROL: rd[SPLIT_BIT] = state_q.dual_eight_bit_select;
      IDX_COMMAND_DIRECTION_CLEAR, IDX_COMMAND_DIRECTION_SET: begin
        rd[LOCK_BIT] = state_q.transfer_lock;
        rd[DIRECTION_BIT] = state_q.direction;
      end
      IDX_BUFFER_VALID_CLEAR, IDX_BUFFER_VALID_SET: begin
        rd[CHANNELS:0] = {state_q.compare_buffer_valid, state_q.period_buffer_valid};
      end
      IDX_FLAGS: rd[WRAP_FLAG_BIT] = state_q.wrap_flag;
      IDX_COUNT: rd[15:0] = state_q.count;
      IDX_PERIOD: rd[15:0] = state_q.period_value;
      IDX_PERIOD_BUFFER: rd[15:0] = state_q.period_buffer;
      default: mapped = 1'b0;
    endcase
    for (int n = 0; n < CHANNELS; n++) begin
      if (idx == IDX_COMPARE_BASE + 8'(2 * n)) begin
        rd[15:0] = state_q.compare_value[n];
        mapped = apb_req.paddr[11:10] == 2'h0;
      end
      if (idx == IDX_COMPARE_BUFFER_BASE + 8'(2 * n)) begin
        rd[15:0] = state_q.compare_buffer[n];
        mapped = apb_req.paddr[11:10] == 2'h0;
      end
    end
    if (setup) begin
      state_d.rdata = apb_req.pwrite ? 32'h0000_0000 : rd;
      state_d.err = !mapped;
    end
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= '0;
      state_q.period_value <= PERIOD_RESET;
      state_q.period_buffer <= PERIOD_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  // Normal and reserved modes never override; the port keeps the pin.
  assign pin_override_active = (state_q.waveform_select != WAVE_NORMAL &&
                                state_q.waveform_select != 3'h2 &&
                                state_q.waveform_select != 3'h4) ?
                               state_q.compare_pin_override_enable : '0;
  assign waveform_pin_output = (pin_override_active & state_q.wave) |
                               (~pin_override_active & port_value);
  assign timer_running = state_q.enable;
  assign dual_eight_bit_select = state_q.dual_eight_bit_select;
  assign count_direction = state_q.direction;
  assign apb_rsp.prdata = state_q.rdata;
  assign apb_rsp.pready = apb_req.psel && apb_req.penable;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && state_q.err;

endmodule

// ===== shared/twc_pkg.sv
// Package of the timer waveform control block: register indices, field
// positions, reset values, mode codes and the bus carriers.
// Assumes a 32-bit APB master and one clock for the whole block.
package twc_pkg;

  // ---------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL_A = 8'h00;
  localparam logic [7:0] IDX_WAVEFORM_MODE_CONTROL = 8'h01;
  localparam logic [7:0] IDX_OUTPUT_VALUE_CONTROL = 8'h02;
  localparam logic [7:0] IDX_SPLIT_SELECT_CONTROL = 8'h03;
  localparam logic [7:0] IDX_COMMAND_DIRECTION_CLEAR = 8'h04;
  localparam logic [7:0] IDX_COMMAND_DIRECTION_SET = 8'h05;
  localparam logic [7:0] IDX_BUFFER_VALID_CLEAR = 8'h06;
  localparam logic [7:0] IDX_BUFFER_VALID_SET = 8'h07;
  localparam logic [7:0] IDX_FLAGS = 8'h0b;
  localparam logic [7:0] IDX_COUNT = 8'h20;
  localparam logic [7:0] IDX_PERIOD = 8'h26;
  localparam logic [7:0] IDX_COMPARE_BASE = 8'h28;
  localparam logic [7:0] IDX_PERIOD_BUFFER = 8'h36;
  localparam logic [7:0] IDX_COMPARE_BUFFER_BASE = 8'h38;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int ENABLE_BIT = 0;
  localparam int PRESCALE_LSB = 1;
  localparam int WAVEFORM_SELECT_LSB = 0;
  localparam int AUTO_LOCK_BIT = 3;
  localparam int OVERRIDE_LSB = 4;
  localparam int DIRECTION_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int COMMAND_LSB = 2;
  localparam int SPLIT_BIT = 0;
  localparam int WRAP_FLAG_BIT = 0;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [15:0] PERIOD_RESET = 16'hffff;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // ---------------------------------------------------------------------
  // Modes and commands
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    WAVE_NORMAL = 3'h0,
    WAVE_FREQUENCY = 3'h1,
    WAVE_ONE_RAMP_PWM = 3'h3,
    WAVE_TWO_RAMP_FLAG_AT_PEAK = 3'h5,
    WAVE_TWO_RAMP_FLAG_AT_BOTH = 3'h6,
    WAVE_TWO_RAMP_FLAG_AT_FLOOR = 3'h7
  } twc_wave_t;

  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_UPDATE = 2'h1;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_HARD_RESET = 2'h3;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } twc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } twc_apb_rsp_t;

endpackage
